// [hdl/status_reporting_regs.vh]
// register offsets, field positions and reset values of the status reporting block
`ifndef STATUS_REPORTING_REGS_VH
`define STATUS_REPORTING_REGS_VH

// ============================================================
// widths
`define SR_STD_W            8
`define SR_SET_W            16
`define SR_ADDR_W           8

// ============================================================
// byte offsets of the registers
`define SR_ADDR_STATUS_BYTE 8'h00
`define SR_ADDR_SRQ_ENABLE  8'h04
`define SR_ADDR_STD_EVENT   8'h08
`define SR_ADDR_STD_ENABLE  8'h0C
`define SR_ADDR_OP_COND     8'h10
`define SR_ADDR_OP_EVENT    8'h14
`define SR_ADDR_OP_ENABLE   8'h18
`define SR_ADDR_QUES_COND   8'h1C
`define SR_ADDR_QUES_EVENT  8'h20
`define SR_ADDR_QUES_ENABLE 8'h24
`define SR_ADDR_CLEAR_STAT  8'h28

// ============================================================
// status byte field positions
`define SR_BIT_OP_SUM       7
`define SR_BIT_MASTER       6
`define SR_BIT_STD_SUM      5
`define SR_BIT_MSG_AVAIL    4
`define SR_BIT_QUES_SUM     3

// ============================================================
// writable bits of the service request mask (master bit excluded)
`define SR_SRQ_WR_MASK      8'hB8

// ============================================================
// reset values
`define SR_RST_STD          8'h00
`define SR_RST_SET          16'h0000
`define SR_RST_DATA         32'h0000_0000

`endif

// [hdl/status_reporting.v]
// status byte, service request mask and three event register sets behind a wishbone slave
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "status_reporting_regs.vh"

// Function
// [RULE1] read-only status byte, not latched, holding every set's summary bit
// [RULE2] master summary flag set when any summary bit meets its mask bit
// [RULE3] service request mask is writable and reads back
// [RULE4] operation and questionable sets have condition registers; standard set has none
// [RULE5] condition registers show live status, never latched, read-only
// [RULE6] event bit latches on its event; repeats while set change nothing
// [RULE7] event bits hold until clearing read or clear-status; never written
// [RULE8] set summary bit high when any event bit meets its enable bit
// [RULE9] every enable register is writable and reads back
// [RULE10] a read returns the binary weighted value of the set bits
// [RULE11] only enable registers accept writes, value is the weighted bit sum
// [RULE12] writing zero clears an enable; all enables clear at power-on
// [RULE13] reading the standard event register returns it and then clears it
// [RULE14] clear-status clears every event register, dropping all summary bits
// [RULE15] nothing clears the status byte directly; summaries fall with their events
// [RULE16] power-on clears event registers; status byte has no summary bits
// [RULE17] byte layout: op 7, master 6, standard 5, message 4, questionable 3
// [RULE18] reading the status byte does not clear the master summary flag
// [RULE19] message-available follows the output buffer holding a message
// [RULE20] an event in the cycle of a clear leaves its bit set
// [RULE21] summaries derive from current event and enable contents, next cycle
module status_reporting (
    input  wire                     clk_i,
    input  wire                     rst_i,
    // wishbone classic slave
    input  wire                     wb_cyc_i,
    input  wire                     wb_stb_i,
    input  wire                     wb_we_i,
    input  wire [`SR_ADDR_W-1:0]    wb_adr_i,
    input  wire [3:0]               wb_sel_i,
    input  wire [31:0]              wb_dat_i,
    output wire [31:0]              wb_dat_o,
    output wire                     wb_ack_o,
    // instrument side
    input  wire [`SR_STD_W-1:0]     std_event_i,
    input  wire [`SR_SET_W-1:0]     op_cond_i,
    input  wire [`SR_SET_W-1:0]     ques_cond_i,
    input  wire                     message_available_flag_i,
    // status outputs
    output wire [7:0]               status_byte_o,
    output wire                     master_summary_flag_o
);

    // ============================================================
    // state
    reg  [31:0]             dat_reg;
    reg  [31:0]             dat_next;
    reg                     ack_reg;
    reg  [`SR_STD_W-1:0]    std_event_reg;
    reg  [`SR_STD_W-1:0]    std_enable_reg;
    reg  [7:0]              srq_enable_reg;
    reg  [`SR_SET_W-1:0]    op_cond_reg;
    reg  [`SR_SET_W-1:0]    op_event_reg;
    reg  [`SR_SET_W-1:0]    op_enable_reg;
    reg  [`SR_SET_W-1:0]    ques_cond_reg;
    reg  [`SR_SET_W-1:0]    ques_event_reg;
    reg  [`SR_SET_W-1:0]    ques_enable_reg;
    reg  [7:0]              status_byte_reg;
    reg                     master_reg;
    reg                     msg_avail_reg;

    // ============================================================
    // bus decode
    wire                    req_take;
    wire                    wr_take;
    wire                    rd_take;
    wire [15:0]             lane_mask;
    wire                    hit_status;
    wire                    hit_srq;
    wire                    hit_std_ev;
    wire                    hit_std_en;
    wire                    hit_op_cond;
    wire                    hit_op_ev;
    wire                    hit_op_en;
    wire                    hit_ques_cond;
    wire                    hit_ques_ev;
    wire                    hit_ques_en;
    wire                    hit_clear;

    assign req_take      = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr_take       = req_take & wb_we_i;
    assign rd_take       = req_take & ~wb_we_i;
    assign lane_mask     = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    assign hit_status    = (wb_adr_i == `SR_ADDR_STATUS_BYTE);
    assign hit_srq       = (wb_adr_i == `SR_ADDR_SRQ_ENABLE);
    assign hit_std_ev    = (wb_adr_i == `SR_ADDR_STD_EVENT);
    assign hit_std_en    = (wb_adr_i == `SR_ADDR_STD_ENABLE);
    assign hit_op_cond   = (wb_adr_i == `SR_ADDR_OP_COND);
    assign hit_op_ev     = (wb_adr_i == `SR_ADDR_OP_EVENT);
    assign hit_op_en     = (wb_adr_i == `SR_ADDR_OP_ENABLE);
    assign hit_ques_cond = (wb_adr_i == `SR_ADDR_QUES_COND);
    assign hit_ques_ev   = (wb_adr_i == `SR_ADDR_QUES_EVENT);
    assign hit_ques_en   = (wb_adr_i == `SR_ADDR_QUES_ENABLE);
    assign hit_clear     = (wb_adr_i == `SR_ADDR_CLEAR_STAT);

    // ============================================================
    // clear requests for the event registers
    wire                    clear_status;
    wire                    clr_std;
    wire                    clr_op;
    wire                    clr_ques;

    assign clear_status  = wr_take & hit_clear;                  // [RULE14]
    assign clr_std       = clear_status | (rd_take & hit_std_ev); // [RULE13]
    assign clr_op        = clear_status | (rd_take & hit_op_ev);  // [RULE7]
    assign clr_ques      = clear_status | (rd_take & hit_ques_ev); // [RULE7]

    // ============================================================
    // event sources: condition rising edges for op and questionable sets
    wire [`SR_SET_W-1:0]    op_rise;
    wire [`SR_SET_W-1:0]    ques_rise;

    assign op_rise   = op_cond_i & ~op_cond_reg;
    assign ques_rise = ques_cond_i & ~ques_cond_reg;

    // ============================================================
    // summaries from current event and enable contents
    wire                    std_sum;
    wire                    op_sum;
    wire                    ques_sum;
    reg  [7:0]              status_next;

    assign std_sum  = |(std_event_reg & std_enable_reg);         // [RULE8]
    assign op_sum   = |(op_event_reg & op_enable_reg);           // [RULE8]
    assign ques_sum = |(ques_event_reg & ques_enable_reg);       // [RULE8]

    always @* begin
        status_next                       = 8'h00;
        status_next[`SR_BIT_OP_SUM]       = op_sum;              // [RULE17]
        status_next[`SR_BIT_STD_SUM]      = std_sum;             // [RULE17]
        status_next[`SR_BIT_MSG_AVAIL]    = msg_avail_reg;       // [RULE19]
        status_next[`SR_BIT_QUES_SUM]     = ques_sum;            // [RULE17]
        // master bit from summaries meeting the mask, never from itself
        status_next[`SR_BIT_MASTER]       = |(status_next & srq_enable_reg & `SR_SRQ_WR_MASK); // [RULE2]
    end

    // ============================================================
    // read data mux
    always @* begin
        dat_next = `SR_RST_DATA;
        if (rd_take) begin
            if (hit_status) begin
                dat_next[7:0] = status_byte_reg;                 // [RULE18]
            end else if (hit_srq) begin
                dat_next[7:0] = srq_enable_reg;                  // [RULE3]
            end else if (hit_std_ev) begin
                dat_next[`SR_STD_W-1:0] = std_event_reg;         // [RULE10]
            end else if (hit_std_en) begin
                dat_next[`SR_STD_W-1:0] = std_enable_reg;        // [RULE9]
            end else if (hit_op_cond) begin
                dat_next[`SR_SET_W-1:0] = op_cond_reg;           // [RULE5]
            end else if (hit_op_ev) begin
                dat_next[`SR_SET_W-1:0] = op_event_reg;          // [RULE10]
            end else if (hit_op_en) begin
                dat_next[`SR_SET_W-1:0] = op_enable_reg;         // [RULE9]
            end else if (hit_ques_cond) begin
                dat_next[`SR_SET_W-1:0] = ques_cond_reg;         // [RULE5]
            end else if (hit_ques_ev) begin
                dat_next[`SR_SET_W-1:0] = ques_event_reg;        // [RULE10]
            end else if (hit_ques_en) begin
                dat_next[`SR_SET_W-1:0] = ques_enable_reg;       // [RULE9]
            end
        end
    end

    // ============================================================
    // bus response: one wait state, ack for one cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= `SR_RST_DATA;
        end else begin
            ack_reg <= req_take;
            dat_reg <= dat_next;                                 // [RULE10]
        end
    end

    // ============================================================
    // enable registers, the only writable state
    always @(posedge clk_i) begin
        if (rst_i) begin
            srq_enable_reg  <= 8'h00;                            // [RULE12]
            std_enable_reg  <= `SR_RST_STD;                      // [RULE12]
            op_enable_reg   <= `SR_RST_SET;                      // [RULE12]
            ques_enable_reg <= `SR_RST_SET;                      // [RULE12]
        end else if (wr_take) begin
            if (hit_srq && wb_sel_i[0]) begin
                srq_enable_reg <= wb_dat_i[7:0] & `SR_SRQ_WR_MASK; // [RULE3]
            end
            if (hit_std_en && wb_sel_i[0]) begin
                std_enable_reg <= wb_dat_i[`SR_STD_W-1:0];       // [RULE11]
            end
            if (hit_op_en) begin
                op_enable_reg <= (op_enable_reg & ~lane_mask) | (wb_dat_i[15:0] & lane_mask); // [RULE11]
            end
            if (hit_ques_en) begin
                ques_enable_reg <= (ques_enable_reg & ~lane_mask) | (wb_dat_i[15:0] & lane_mask); // [RULE11]
            end
        end
    end

    // ============================================================
    // condition registers track the instrument every cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            op_cond_reg   <= `SR_RST_SET;
            ques_cond_reg <= `SR_RST_SET;
            msg_avail_reg <= 1'b0;
        end else begin
            op_cond_reg   <= op_cond_i;                          // [RULE4]
            ques_cond_reg <= ques_cond_i;                        // [RULE5]
            msg_avail_reg <= message_available_flag_i;           // [RULE19]
        end
    end

    // ============================================================
    // event registers: sticky, cleared by read or clear-status, set wins
    always @(posedge clk_i) begin
        if (rst_i) begin
            std_event_reg  <= `SR_RST_STD;                       // [RULE16]
            op_event_reg   <= `SR_RST_SET;                       // [RULE16]
            ques_event_reg <= `SR_RST_SET;                       // [RULE16]
        end else begin
            std_event_reg  <= (std_event_reg & {`SR_STD_W{~clr_std}}) | std_event_i;  // [RULE6] [RULE20]
            op_event_reg   <= (op_event_reg & {`SR_SET_W{~clr_op}}) | op_rise;        // [RULE6] [RULE20]
            ques_event_reg <= (ques_event_reg & {`SR_SET_W{~clr_ques}}) | ques_rise;  // [RULE6] [RULE20]
        end
    end

    // ============================================================
    // status byte, rebuilt every cycle, no clear path of its own
    always @(posedge clk_i) begin
        if (rst_i) begin
            status_byte_reg <= 8'h00;                            // [RULE16]
            master_reg      <= 1'b0;
        end else begin
            status_byte_reg <= status_next;                      // [RULE1] [RULE15] [RULE21]
            master_reg      <= status_next[`SR_BIT_MASTER];      // [RULE2] [RULE18]
        end
    end

    // ============================================================
    // outputs
    assign wb_dat_o              = dat_reg;
    assign wb_ack_o              = ack_reg;
    assign status_byte_o         = status_byte_reg;
    assign master_summary_flag_o = master_reg;

endmodule // status_reporting
`default_nettype wire

// [verif/wb_host.sv]
// wishbone host model issuing status queries and commands
`timescale 1ns/10ps
`default_nettype none
module wb_host (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    output var  logic        cyc_o,
    output var  logic        stb_o,
    output var  logic        we_o,
    output var  logic [7:0]  adr_o,
    output var  logic [3:0]  sel_o,
    output var  logic [31:0] dat_o
);
    initial begin
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    end
    // one classic cycle, held until ack is sampled
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= wr;
        adr_o <= a;
        sel_o <= 4'h3;
        dat_o <= d;
        @(posedge clk_i);
        while (ack_i !== 1'b1) @(posedge clk_i);
        {cyc_o, stb_o, we_o} <= 3'h0;
    endtask
endmodule // wb_host
`default_nettype wire

// [verif/status_reporting_asserts.sv]
// assertions on the status reporting ports
`timescale 1ns/10ps
`default_nettype none
module status_reporting_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [7:0]  std_event_i,
    input wire logic [15:0] op_cond_i,
    input wire logic [15:0] ques_cond_i,
    input wire logic        message_available_flag_i,
    input wire logic [7:0]  status_byte_o,
    input wire logic        master_summary_flag_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // ============================================================
    // assertions
    chk_ack_after_take: assert property (take |=> wb_ack_o) else $error("ack late");
    chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
    chk_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("stray data");
    chk_master_mirror: assert property (master_summary_flag_o == status_byte_o[6]) else $error("flag");
    chk_low_bits_zero: assert property (status_byte_o[2:0] == 3'h0) else $error("low bits");
    chk_master_cause: assert property (status_byte_o[6] |-> |(status_byte_o & 8'hB8))
        else $error("master alone");
    chk_msg_follow: assert property (status_byte_o[4] == $past(message_available_flag_i, 2))
        else $error("msg bit");
    chk_std_read_clear: assert property (std_event_i == 8'h0
        ##1 (take && !wb_we_i && wb_adr_i == 8'h08 && std_event_i == 8'h0)
        |=> ##1 !status_byte_o[5]) else $error("std sum held");
    chk_clear_all_sums: assert property ($stable(op_cond_i) && $stable(ques_cond_i)
        && std_event_i == 8'h0
        ##1 (take && wb_we_i && wb_adr_i == 8'h28 && std_event_i == 8'h0 && $stable(op_cond_i)
        && $stable(ques_cond_i)) |=> ##1 (status_byte_o & 8'hA8) == 8'h0) else $error("sums held");
endmodule // status_reporting_asserts
bind status_reporting status_reporting_asserts chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .std_event_i(std_event_i), .op_cond_i(op_cond_i), .ques_cond_i(ques_cond_i),
    .message_available_flag_i(message_available_flag_i), .status_byte_o(status_byte_o),
    .master_summary_flag_o(master_summary_flag_o));
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the status reporting block
`timescale 1ns/10ps
`default_nettype none
`include "status_reporting_regs.vh"
module testbench;
    logic        clk_i = 1'b0, rst_i = 1'b1, msg;
    logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, message_available_flag_i, master_summary_flag_o;
    logic [3:0]  wb_sel_i;
    logic [7:0]  wb_adr_i, std_event_i, status_byte_o, std_ev, std_en, srq, v;
    logic [15:0] op_cond_i, ques_cond_i, op_ev, op_en, qu_ev, qu_en;
    logic [31:0] wb_dat_i, wb_dat_o, c, exp_q[$];
    int          num_errors = 0, checks_done = 0;
    always #5 clk_i = ~clk_i;
    status_reporting dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .std_event_i(std_event_i), .op_cond_i(op_cond_i),
        .ques_cond_i(ques_cond_i), .message_available_flag_i(message_available_flag_i),
        .status_byte_o(status_byte_o), .master_summary_flag_o(master_summary_flag_o));
    wb_host host (.clk_i(clk_i), .ack_i(wb_ack_o), .cyc_o(wb_cyc_i), .stb_o(wb_stb_i), .we_o(wb_we_i),
        .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i));
    // ============================================================
    // helpers
    function automatic logic [7:0] exp_sb();
        logic [7:0] s;
        s = {|(op_ev & op_en), 1'b0, |(std_ev & std_en), msg, |(qu_ev & qu_en), 3'h0};
        s[6] = |(s & srq);
        return s;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        checks_done++;
        if (seen !== expd) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expd);
        end
    endtask
    task automatic report_and_stop();
        if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.access(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        host.access(1'b0, a, 32'h0);
    endtask
    task automatic sb_check();
        logic [7:0] e;
        repeat (4) @(posedge clk_i);
        e = exp_sb();
        check({23'h0, master_summary_flag_o, status_byte_o}, {23'h0, e[6], e});
    endtask
    task automatic pulse(input logic [7:0] p);
        @(posedge clk_i);
        std_event_i <= p;
        @(posedge clk_i);
        std_event_i <= 8'h0;
    endtask
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) check(wb_dat_o, exp_q.pop_front());
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        report_and_stop();
    end
    // ============================================================
    // main sequence
    initial begin
        {std_event_i, op_cond_i, ques_cond_i, message_available_flag_i} = '0;
        {std_ev, std_en, srq, msg, op_ev, op_en, qu_ev, qu_en} = '0;
        void'($urandom(14));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        sb_check();
        for (int a = 0; a < 'h2C; a += 4) rd(8'(a), 32'h0);
        {std_en, v} = {8'($urandom) | 8'h01, 8'($urandom)};
        {op_en, qu_en} = $urandom | 32'h0001_0001;
        wr(`SR_ADDR_STD_ENABLE, {24'h0, std_en});
        wr(`SR_ADDR_OP_ENABLE, {16'h0, op_en});
        wr(`SR_ADDR_QUES_ENABLE, {16'h0, qu_en});
        wr(`SR_ADDR_SRQ_ENABLE, {24'h0, v});
        rd(`SR_ADDR_SRQ_ENABLE, {24'h0, v & `SR_SRQ_WR_MASK});
        rd(`SR_ADDR_STD_ENABLE, {24'h0, std_en});
        rd(`SR_ADDR_OP_ENABLE, {16'h0, op_en});
        rd(`SR_ADDR_QUES_ENABLE, {16'h0, qu_en});
        wr(`SR_ADDR_SRQ_ENABLE, 32'hFF);
        srq = `SR_SRQ_WR_MASK;
        wr(`SR_ADDR_STD_EVENT, 32'hFF);
        wr(8'h3C, 32'hFF);
        rd(`SR_ADDR_STD_EVENT, 32'h0);
        rd(8'h3C, 32'h0);
        v = 8'($urandom) | 8'h01;
        pulse(v);
        pulse(v);
        std_ev = v;
        sb_check();
        rd(`SR_ADDR_STATUS_BYTE, {24'h0, exp_sb()});
        sb_check();
        rd(`SR_ADDR_STD_EVENT, {24'h0, v});
        std_ev = 8'h0;
        sb_check();
        rd(`SR_ADDR_STD_EVENT, 32'h0);
        c = $urandom | 32'h0001_0001;
        {ques_cond_i, op_cond_i} <= c;
        {qu_ev, op_ev} = c;
        sb_check();
        rd(`SR_ADDR_OP_COND, {16'h0, c[15:0]});
        rd(`SR_ADDR_QUES_COND, {16'h0, c[31:16]});
        {ques_cond_i, op_cond_i, message_available_flag_i} <= 33'h1;
        msg = 1'b1;
        sb_check();
        rd(`SR_ADDR_OP_COND, 32'h0);
        pulse(v);
        wr(`SR_ADDR_CLEAR_STAT, 32'h0);
        {qu_ev, op_ev} = 32'h0;
        sb_check();
        rd(`SR_ADDR_OP_EVENT, 32'h0);
        rd(`SR_ADDR_QUES_EVENT, 32'h0);
        message_available_flag_i <= 1'b0;
        msg = 1'b0;
        sb_check();
        {ques_cond_i, op_cond_i} <= c;
        {qu_ev, op_ev} = c;
        pulse(v);
        std_ev = v;
        sb_check();
        rd(`SR_ADDR_OP_EVENT, {16'h0, c[15:0]});
        rd(`SR_ADDR_QUES_EVENT, {16'h0, c[31:16]});
        {qu_ev, op_ev} = 32'h0;
        wr(`SR_ADDR_STD_ENABLE, 32'h0);
        std_en = 8'h0;
        sb_check();
        rd(`SR_ADDR_STD_ENABLE, 32'h0);
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
